// ### plptr_readout.sv
// LED pulse timing registers and sensor result registers of the proximity and light readout
// What this block does and what the host must keep to
// RULE1: LED pulse rate is the 4 MHz reference divided by the divider register.
// RULE2: Divider register resets to 0x10, giving 250 KHz, four microsecond period.
// RULE3: Host should keep the pulse rate between 200 KHz and 1 MHz.
// RULE4: Receiver samples a programmable delay after each LED turn-on edge.
// RULE5: Delay code 0 or 1 means none; N from 2 to 31 gives (N-1)x125 ns.
// RULE6: Host keeps the delay code no greater than the divider value.
// RULE7: Sample delay register resets to 0x05, a 500 ns delay.
// RULE8: Proximity result is unsigned, 12 bits at default integration, readable by host.
// RULE9: Proximity result width runs from 11 bits up to 16 bits with integration time.
// RULE10: Each light channel stores a 16-bit unsigned count in its own register.
// RULE11: Light channels enable independently; a disabled channel powers down and converts nothing.
// RULE12: LED is lit half of each period; sampling counts from the lit edge.
`timescale 1ns/100ps
`include "plptr_map.svh"
module plptr_readout
(
   input wire logic clock,
   input wire logic rst_n,
   input wire logic [`PLPTR_ADDR_WIDTH-1:0] reg_addr,
   input wire logic reg_write,
   input wire logic [`PLPTR_DATA_WIDTH-1:0] reg_wdata,
   input wire logic reg_read,
   output logic [`PLPTR_DATA_WIDTH-1:0] reg_rdata,
   input wire logic [2:0] prox_int_time,
   input wire logic [15:0] prox_conv_count,
   input wire logic prox_conv_valid,
   input wire logic filtered_light_enable,
   input wire logic [15:0] filtered_conv_count,
   input wire logic filtered_conv_valid,
   input wire logic unfiltered_light_enable,
   input wire logic [15:0] unfiltered_conv_count,
   input wire logic unfiltered_conv_valid,
   output logic led_drive,
   output logic receiver_sample,
   output logic led_period_start,
   output logic filtered_light_power_down,
   output logic unfiltered_light_power_down
);
   plptr_timing_if tif ();

   logic [7:0] led_pulse_divider;
   logic [7:0] receiver_sample_delay;
   logic [15:0] proximity_result;
   logic [15:0] filtered_light_result;
   logic [15:0] unfiltered_light_result;
   logic [15:0] prox_limit;
   logic [15:0] next_proximity;
   logic [7:0] next_rdata;
   logic divider_write;
   logic delay_write;
   logic filtered_take;
   logic unfiltered_take;

   plptr_pulse_timer u_timer
   (
      .clock(clock),
      .rst_n(rst_n),
      .tif(tif)
   );

   assign tif.divider = led_pulse_divider;
   assign tif.delay = receiver_sample_delay;

   // RULE12 lit half phase
   assign led_drive = tif.led_on;
   // RULE4 sample strobe out
   assign receiver_sample = tif.sample_strobe;
   assign led_period_start = tif.period_start;

   // Writes land only at the two timing offsets; the result offsets stay read-only
   assign divider_write = reg_write && (reg_addr == `PLPTR_OFS_LED_PULSE_DIVIDER);
   assign delay_write = reg_write && (reg_addr == `PLPTR_OFS_RECEIVER_SAMPLE_DELAY);

   // RULE2 divider reset value
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         led_pulse_divider <= `PLPTR_RST_LED_PULSE_DIVIDER;
      end
      else if (divider_write)
      begin
         led_pulse_divider <= reg_wdata;
      end
   end

   // RULE7 delay reset value
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         receiver_sample_delay <= `PLPTR_RST_RECEIVER_SAMPLE_DELAY;
      end
      else if (delay_write)
      begin
         receiver_sample_delay <= reg_wdata;
      end
   end

   // RULE9 width by integration
   always_comb
   begin
      case (plptr_pkg::plptr_int_time_type'(prox_int_time))
         plptr_pkg::PLPTR_TINT_150:
         begin
            prox_limit = 16'h07FF;
         end
         plptr_pkg::PLPTR_TINT_300:
         begin
            prox_limit = 16'h0FFF;
         end
         plptr_pkg::PLPTR_TINT_600:
         begin
            prox_limit = 16'h1FFF;
         end
         plptr_pkg::PLPTR_TINT_1200:
         begin
            prox_limit = 16'h3FFF;
         end
         plptr_pkg::PLPTR_TINT_1800:
         begin
            prox_limit = 16'h7FFF;
         end
         plptr_pkg::PLPTR_TINT_2400:
         begin
            prox_limit = 16'h7FFF;
         end
         plptr_pkg::PLPTR_TINT_3600:
         begin
            prox_limit = 16'hFFFF;
         end
         plptr_pkg::PLPTR_TINT_4800:
         begin
            prox_limit = 16'hFFFF;
         end
         default:
         begin
            prox_limit = 16'h0FFF;
         end
      endcase
   end

   // Saturating rather than truncating keeps a strong reflection reading as near, not wrapped to far
   assign next_proximity = (prox_conv_count > prox_limit) ? prox_limit : prox_conv_count;

   // RULE8 proximity result store
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         proximity_result <= `PLPTR_RST_RESULT;
      end
      else if (prox_conv_valid)
      begin
         proximity_result <= next_proximity;
      end
   end

   // RULE11 power down disabled
   assign filtered_light_power_down = !filtered_light_enable;
   assign unfiltered_light_power_down = !unfiltered_light_enable;

   // RULE11 gated result capture
   // A converter finishing as its channel is switched off must not overwrite the held count
   assign filtered_take = filtered_conv_valid && filtered_light_enable;
   assign unfiltered_take = unfiltered_conv_valid && unfiltered_light_enable;

   // RULE10 filtered count store
   // RULE11 disabled ignores results
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         filtered_light_result <= `PLPTR_RST_RESULT;
      end
      else if (filtered_take)
      begin
         filtered_light_result <= filtered_conv_count;
      end
   end

   // RULE10 unfiltered count store
   // RULE11 disabled ignores results
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         unfiltered_light_result <= `PLPTR_RST_RESULT;
      end
      else if (unfiltered_take)
      begin
         unfiltered_light_result <= unfiltered_conv_count;
      end
   end

   always_comb
   begin
      case (reg_addr)
         `PLPTR_OFS_LED_PULSE_DIVIDER: next_rdata = led_pulse_divider;
         `PLPTR_OFS_RECEIVER_SAMPLE_DELAY: next_rdata = receiver_sample_delay;
         `PLPTR_OFS_PROXIMITY_RESULT_MSB: next_rdata = proximity_result[15:8];
         `PLPTR_OFS_PROXIMITY_RESULT_LSB: next_rdata = proximity_result[7:0];
         `PLPTR_OFS_FILTERED_LIGHT_RESULT_MSB: next_rdata = filtered_light_result[15:8];
         `PLPTR_OFS_FILTERED_LIGHT_RESULT_LSB: next_rdata = filtered_light_result[7:0];
         `PLPTR_OFS_UNFILTERED_LIGHT_RESULT_MSB: next_rdata = unfiltered_light_result[15:8];
         `PLPTR_OFS_UNFILTERED_LIGHT_RESULT_LSB: next_rdata = unfiltered_light_result[7:0];
         default: next_rdata = `PLPTR_UNMAPPED_READ;
      endcase
   end

   // Read data is held between reads so the serial shifter can take it at leisure
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         reg_rdata <= `PLPTR_UNMAPPED_READ;
      end
      else if (reg_read)
      begin
         reg_rdata <= next_rdata;
      end
   end

endmodule : plptr_readout

// ### plptr_map.svh
// Register offsets, reset values, field positions and timing figures of the LED pulse and readout block
`ifndef PLPTR_MAP_SVH
`define PLPTR_MAP_SVH

`define PLPTR_ADDR_WIDTH 8
`define PLPTR_DATA_WIDTH 8

`define PLPTR_OFS_LED_PULSE_DIVIDER 8'h0D
`define PLPTR_OFS_RECEIVER_SAMPLE_DELAY 8'h0E
`define PLPTR_OFS_PROXIMITY_RESULT_MSB 8'h41
`define PLPTR_OFS_PROXIMITY_RESULT_LSB 8'h42
`define PLPTR_OFS_FILTERED_LIGHT_RESULT_MSB 8'h43
`define PLPTR_OFS_FILTERED_LIGHT_RESULT_LSB 8'h44
`define PLPTR_OFS_UNFILTERED_LIGHT_RESULT_MSB 8'h45
`define PLPTR_OFS_UNFILTERED_LIGHT_RESULT_LSB 8'h46

`define PLPTR_RST_LED_PULSE_DIVIDER 8'h10
`define PLPTR_RST_RECEIVER_SAMPLE_DELAY 8'h05
`define PLPTR_RST_RESULT 16'h0000
`define PLPTR_UNMAPPED_READ 8'h00

// Sample delay code occupies the low five bits
`define PLPTR_DELAY_CODE_MSB 4
`define PLPTR_DELAY_CODE_LSB 0

`define PLPTR_CLK_PERIOD_NS 100
`define PLPTR_REF_FREQ_HZ 4000000
`define PLPTR_DELAY_STEP_NS 125
`define PLPTR_TIME_UNIT_NS 25

`endif

// ### plptr_pkg.sv
// Types shared by the LED pulse and readout block
package plptr_pkg;

   typedef enum logic [1:0]
   {
      PLPTR_STOPPED = 2'b00,
      PLPTR_LIT = 2'b01,
      PLPTR_DARK = 2'b10
   } plptr_led_phase_type;

   typedef enum logic [2:0]
   {
      PLPTR_TINT_150 = 3'b000,
      PLPTR_TINT_300 = 3'b001,
      PLPTR_TINT_600 = 3'b010,
      PLPTR_TINT_1200 = 3'b011,
      PLPTR_TINT_1800 = 3'b100,
      PLPTR_TINT_2400 = 3'b101,
      PLPTR_TINT_3600 = 3'b110,
      PLPTR_TINT_4800 = 3'b111
   } plptr_int_time_type;

endpackage : plptr_pkg

// ### plptr_timing_if.sv
// Settings and pulse timing passed between the register bank and the pulse timer
`timescale 1ns/100ps
interface plptr_timing_if;
   logic [7:0] divider;
   logic [7:0] delay;
   logic led_on;
   logic sample_strobe;
   logic period_start;

   modport ctrl
   (
      output divider,
      output delay,
      input led_on,
      input sample_strobe,
      input period_start
   );

   modport timer
   (
      input divider,
      input delay,
      output led_on,
      output sample_strobe,
      output period_start
   );
endinterface : plptr_timing_if

// ### plptr_pulse_timer.sv
// LED pulse generator and receiver sample strobe timer
`timescale 1ns/100ps
`include "plptr_map.svh"
module plptr_pulse_timer
(
   input wire logic clock,
   input wire logic rst_n,
   plptr_timing_if.timer tif
);
   // Time is tracked in 25 ns units, the common step of the 100 ns clock and the 125 ns delay grain
   localparam int unsigned STEP_UNITS = `PLPTR_CLK_PERIOD_NS / `PLPTR_TIME_UNIT_NS;
   localparam int unsigned REF_PERIOD_NS = 1000000000 / `PLPTR_REF_FREQ_HZ;
   localparam int unsigned REF_UNITS = REF_PERIOD_NS / `PLPTR_TIME_UNIT_NS;
   localparam int unsigned DELAY_UNITS = `PLPTR_DELAY_STEP_NS / `PLPTR_TIME_UNIT_NS;

   plptr_pkg::plptr_led_phase_type state;
   plptr_pkg::plptr_led_phase_type next_state;
   logic [11:0] phase;
   logic [11:0] next_phase;
   logic [11:0] period_units;
   logic [11:0] half_units;
   logic [11:0] delay_units;
   logic [12:0] sum;
   logic [11:0] remainder;
   logic wrap;
   logic new_period;
   logic sampled;
   logic take;
   logic [4:0] delay_code;

   // RULE1 divided reference
   assign period_units = 12'(int'(tif.divider) * REF_UNITS);
   // RULE12 half lit
   assign half_units = {1'b0, period_units[11:1]};
   assign delay_code = tif.delay[`PLPTR_DELAY_CODE_MSB:`PLPTR_DELAY_CODE_LSB];

   // RULE5 delay encoding
   always_comb
   begin
      if (delay_code > 5'h01)
      begin
         delay_units = 12'((int'(delay_code) - 1) * DELAY_UNITS);
      end
      else
      begin
         delay_units = 12'h000;
      end
   end

   always_comb
   begin
      sum = {1'b0, phase} + 13'(STEP_UNITS);
      wrap = (state != plptr_pkg::PLPTR_STOPPED) && (sum >= {1'b0, period_units});
      remainder = 12'(sum - {1'b0, period_units});
      if (wrap)
      begin
         // A divider shrunk mid-period can leave the carry past the lit half; restart so each period opens lit
         if (remainder >= half_units)
         begin
            next_phase = 12'h000;
         end
         else
         begin
            next_phase = remainder;
         end
      end
      else
      begin
         next_phase = sum[11:0];
      end
   end

   always_comb
   begin
      next_state = state;
      case (state)
         plptr_pkg::PLPTR_STOPPED:
         begin
            if (tif.divider != 8'h00)
            begin
               next_state = plptr_pkg::PLPTR_LIT;
            end
         end
         plptr_pkg::PLPTR_LIT, plptr_pkg::PLPTR_DARK:
         begin
            if (tif.divider == 8'h00)
            begin
               next_state = plptr_pkg::PLPTR_STOPPED;
            end
            else if (next_phase < half_units)
            begin
               next_state = plptr_pkg::PLPTR_LIT;
            end
            else
            begin
               next_state = plptr_pkg::PLPTR_DARK;
            end
         end
         default:
         begin
            next_state = plptr_pkg::PLPTR_STOPPED;
         end
      endcase
   end

   assign new_period = (next_state != plptr_pkg::PLPTR_STOPPED) && (wrap || state == plptr_pkg::PLPTR_STOPPED);

   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state <= plptr_pkg::PLPTR_STOPPED;
      end
      else
      begin
         state <= next_state;
      end
   end

   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         phase <= 12'h000;
      end
      else if (state == plptr_pkg::PLPTR_STOPPED || next_state == plptr_pkg::PLPTR_STOPPED)
      begin
         phase <= 12'h000;
      end
      else
      begin
         phase <= next_phase;
      end
   end

   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         tif.period_start <= 1'b0;
      end
      else
      begin
         tif.period_start <= new_period;
      end
   end

   // RULE4 sample after edge
   // A delay longer than the lit phase yields no sample in that period
   // The period start cycle discards the last period's sample, so a zero delay samples on the lit edge itself
   assign take = (state == plptr_pkg::PLPTR_LIT) && (!sampled || tif.period_start) && (phase >= delay_units);

   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         sampled <= 1'b0;
      end
      else if (state == plptr_pkg::PLPTR_STOPPED || tif.period_start)
      begin
         sampled <= take;
      end
      else if (take)
      begin
         sampled <= 1'b1;
      end
   end

   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         tif.sample_strobe <= 1'b0;
      end
      else
      begin
         tif.sample_strobe <= take;
      end
   end

   assign tif.led_on = (state == plptr_pkg::PLPTR_LIT);

endmodule : plptr_pulse_timer

// ### plptr_readout_props.sv
// Concurrent checks on the ports of the LED pulse and readout block
`timescale 1ns/100ps
module plptr_props
(
   input wire logic clock,
   input wire logic rst_n,
   input wire logic [7:0] reg_addr,
   input wire logic reg_read,
   input wire logic [7:0] reg_rdata,
   input wire logic [2:0] prox_int_time,
   input wire logic prox_conv_valid,
   input wire logic filtered_light_enable,
   input wire logic unfiltered_light_enable,
   input wire logic led_drive,
   input wire logic receiver_sample,
   input wire logic led_period_start,
   input wire logic filtered_light_power_down,
   input wire logic unfiltered_light_power_down
);
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!rst_n);

   a_pd_filtered: assert property (filtered_light_power_down == !filtered_light_enable)
      else $error("filtered power down does not follow its enable");
   a_pd_unfiltered: assert property (unfiltered_light_power_down == !unfiltered_light_enable)
      else $error("unfiltered power down does not follow its enable");
   a_sample_when_lit: assert property (receiver_sample |-> $past(led_drive))
      else $error("receiver sampled outside the lit phase");
   a_sample_single: assert property (receiver_sample |=> !receiver_sample)
      else $error("receiver sample longer than one cycle");
   // Holds for dividers of 4 and up, the lowest legal value
   a_lit_run: assert property ($rose(led_drive) |-> led_drive [*4])
      else $error("lit phase shorter than four cycles");
   a_start_lit: assert property (led_period_start |-> led_drive)
      else $error("period began without the LED lit");
   a_prox_twelve: assert property (prox_conv_valid && prox_int_time == 3'h1 ##[1:4] reg_read && reg_addr == 8'h41
      && !prox_conv_valid |=> reg_rdata[7:4] == 4'h0)
      else $error("proximity result wider than twelve bits");
   a_prox_eleven: assert property (prox_conv_valid && prox_int_time == 3'h0 ##[1:4] reg_read && reg_addr == 8'h41
      && !prox_conv_valid |=> reg_rdata[7:3] == 5'h00)
      else $error("proximity result wider than eleven bits");

   c_sample: cover property (receiver_sample);
   c_period: cover property (led_period_start);
   c_result_read: cover property (reg_read && reg_addr == 8'h41);
endmodule : plptr_props

// ### plptr_host.sv
// Host model driving the register side of the readout
`timescale 1ns/100ps
module plptr_host
(
   input wire logic clock,
   output logic [7:0] reg_addr,
   output logic reg_write,
   output logic [7:0] reg_wdata,
   output logic reg_read,
   input wire logic [7:0] reg_rdata
);
   initial
   begin
      reg_addr = 8'h00;
      reg_write = 1'b0;
      reg_wdata = 8'h00;
      reg_read = 1'b0;
   end
   task wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge clock);
      reg_addr = a;
      reg_wdata = d;
      reg_write = 1'b1;
      @(negedge clock);
      reg_write = 1'b0;
      // Released lines show the inverse so stale values never match
      reg_addr = ~a;
      reg_wdata = ~d;
   endtask : wr
   task rd(input logic [7:0] a, output logic [7:0] d);
      @(negedge clock);
      reg_addr = a;
      reg_read = 1'b1;
      @(negedge clock);
      reg_read = 1'b0;
      reg_addr = ~a;
      d = reg_rdata;
   endtask : rd
endmodule : plptr_host

// ### test_prox_led_pulse_timing_readout.sv
// Self-checking bench of the LED pulse and readout block
`timescale 1ns/100ps
module test_prox_led_pulse_timing_readout;
   logic clock, rst_n, reg_write, reg_read, prox_conv_valid, filtered_light_enable, unfiltered_light_enable;
   logic filtered_conv_valid, unfiltered_conv_valid, led_drive, receiver_sample, led_period_start;
   logic filtered_light_power_down, unfiltered_light_power_down;
   logic [7:0] reg_addr, reg_wdata, reg_rdata;
   logic [2:0] prox_int_time;
   logic [15:0] prox_conv_count, filtered_conv_count, unfiltered_conv_count;
   int error_cnt = 0;
   int tests_run = 0;

   plptr_readout u_dut (.clock(clock), .rst_n(rst_n), .reg_addr(reg_addr), .reg_write(reg_write),
      .reg_wdata(reg_wdata), .reg_read(reg_read), .reg_rdata(reg_rdata), .prox_int_time(prox_int_time),
      .prox_conv_count(prox_conv_count), .prox_conv_valid(prox_conv_valid),
      .filtered_light_enable(filtered_light_enable), .filtered_conv_count(filtered_conv_count),
      .filtered_conv_valid(filtered_conv_valid), .unfiltered_light_enable(unfiltered_light_enable),
      .unfiltered_conv_count(unfiltered_conv_count), .unfiltered_conv_valid(unfiltered_conv_valid),
      .led_drive(led_drive), .receiver_sample(receiver_sample), .led_period_start(led_period_start),
      .filtered_light_power_down(filtered_light_power_down),
      .unfiltered_light_power_down(unfiltered_light_power_down));
   plptr_host u_host (.clock(clock), .reg_addr(reg_addr), .reg_write(reg_write), .reg_wdata(reg_wdata),
      .reg_read(reg_read), .reg_rdata(reg_rdata));

   initial
   begin
      clock = 1'b0;
      forever #50 clock = ~clock;
   end

   task chk(input logic [15:0] got, input logic [15:0] exp);
      tests_run++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   task end_of_test;
      $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : end_of_test

   task rd16(input logic [7:0] a, output logic [15:0] v);
      logic [7:0] h, l;
      u_host.rd(a, h);
      u_host.rd(a + 8'h01, l);
      v = {h, l};
   endtask : rd16

   task prox(input logic [15:0] c);
      @(negedge clock);
      prox_conv_count = c;
      prox_conv_valid = 1'b1;
      @(negedge clock);
      prox_conv_valid = 1'b0;
      prox_conv_count = ~c;
   endtask : prox

   task light(input logic [15:0] f, input logic [15:0] u);
      @(negedge clock);
      filtered_conv_count = f;
      unfiltered_conv_count = u;
      filtered_conv_valid = 1'b1;
      unfiltered_conv_valid = 1'b1;
      @(negedge clock);
      filtered_conv_valid = 1'b0;
      unfiltered_conv_valid = 1'b0;
      filtered_conv_count = ~f;
      unfiltered_conv_count = ~u;
   endtask : light

   // Measures one whole period from a period start; ends on the next start
   task meas(output int per, output int lit, output int smp);
      int k;
      per = 0;
      lit = 0;
      smp = 0;
      for (k = 0; k < 300 && led_period_start !== 1'b1; k++)
         @(negedge clock);
      do
      begin
         @(negedge clock);
         per++;
         if (led_drive === 1'b1)
            lit++;
         if (receiver_sample === 1'b1 && smp == 0)
            smp = per;
      end
      while (led_period_start !== 1'b1 && per < 300);
      if (k == 300 || per == 300)
      begin
         error_cnt++;
         end_of_test;
      end
   endtask : meas

   task t_reset;
      logic [7:0] b;
      logic [15:0] v;
      u_host.rd(8'h0D, b);
      chk({8'h00, b}, 16'h0010);
      u_host.rd(8'h0E, b);
      chk({8'h00, b}, 16'h0005);
      u_host.rd(8'h30, b);
      chk({8'h00, b}, 16'h0000);
      rd16(8'h41, v);
      chk(v, 16'h0000);
      $display("test reset done");
   endtask : t_reset

   // Divider writes follow a period start so a lit phase is never cut short
   task t_timing;
      int p, l, s5, s1, s0, s9;
      logic [7:0] b;
      meas(p, l, s5);
      meas(p, l, s5);
      chk(p[15:0], 16'h0028);
      chk(l[15:0], 16'h0014);
      u_host.wr(8'h0E, 8'h01);
      meas(p, l, s1);
      meas(p, l, s1);
      chk(s5[15:0] - s1[15:0], 16'h0005);
      u_host.wr(8'h0E, 8'h00);
      meas(p, l, s0);
      meas(p, l, s0);
      chk(s0[15:0], s1[15:0]);
      u_host.wr(8'h0E, 8'h09);
      meas(p, l, s9);
      meas(p, l, s9);
      chk(s9[15:0] - s5[15:0], 16'h0005);
      u_host.rd(8'h0E, b);
      chk({8'h00, b}, 16'h0009);
      u_host.wr(8'h0D, 8'h08);
      u_host.wr(8'h0E, 8'h05);
      meas(p, l, s5);
      meas(p, l, s5);
      chk(p[15:0], 16'h0014);
      chk(l[15:0], 16'h000A);
      u_host.rd(8'h0D, b);
      chk({8'h00, b}, 16'h0008);
      u_host.wr(8'h0D, 8'h10);
      $display("test timing done");
   endtask : t_timing

   task t_prox;
      int i;
      int w [0:7] = '{11, 12, 13, 14, 15, 15, 16, 16};
      logic [15:0] v;
      for (i = 0; i < 8; i++)
      begin
         prox_int_time = i[2:0];
         prox(16'hFFFF);
         rd16(8'h41, v);
         chk(v, 16'hFFFF >> (16 - w[i]));
      end
      prox_int_time = 3'h1;
      prox(16'h0ABC);
      rd16(8'h41, v);
      chk(v, 16'h0ABC);
      u_host.wr(8'h41, 8'hFF);
      rd16(8'h41, v);
      chk(v, 16'h0ABC);
      $display("test prox done");
   endtask : t_prox

   task t_light;
      logic [15:0] v;
      filtered_light_enable = 1'b1;
      unfiltered_light_enable = 1'b0;
      light(16'h1234, 16'h5678);
      chk({15'h0000, filtered_light_power_down}, 16'h0000);
      chk({15'h0000, unfiltered_light_power_down}, 16'h0001);
      rd16(8'h43, v);
      chk(v, 16'h1234);
      rd16(8'h45, v);
      chk(v, 16'h0000);
      filtered_light_enable = 1'b0;
      unfiltered_light_enable = 1'b1;
      light(16'hFFFF, 16'h8001);
      rd16(8'h43, v);
      chk(v, 16'h1234);
      rd16(8'h45, v);
      chk(v, 16'h8001);
      $display("test light done");
   endtask : t_light

   initial
   begin
      rst_n = 1'b0;
      prox_int_time = 3'h1;
      prox_conv_count = 16'h0000;
      prox_conv_valid = 1'b0;
      filtered_light_enable = 1'b0;
      unfiltered_light_enable = 1'b0;
      filtered_conv_count = 16'h0000;
      unfiltered_conv_count = 16'h0000;
      filtered_conv_valid = 1'b0;
      unfiltered_conv_valid = 1'b0;
      repeat (8) @(negedge clock);
      rst_n = 1'b1;
      t_reset;
      t_timing;
      t_prox;
      t_light;
      end_of_test;
   end
endmodule : test_prox_led_pulse_timing_readout

bind plptr_readout plptr_props u_props (.clock(clock), .rst_n(rst_n), .reg_addr(reg_addr), .reg_read(reg_read),
   .reg_rdata(reg_rdata), .prox_int_time(prox_int_time), .prox_conv_valid(prox_conv_valid),
   .filtered_light_enable(filtered_light_enable), .unfiltered_light_enable(unfiltered_light_enable),
   .led_drive(led_drive), .receiver_sample(receiver_sample), .led_period_start(led_period_start),
   .filtered_light_power_down(filtered_light_power_down),
   .unfiltered_light_power_down(unfiltered_light_power_down));
